//--- logic/adt_debug_ctrl.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Writing 1 to bit 9 of the second word enters read-back mode.
// - Data-ready output stays inactive throughout read-back mode.
// - Read-back reads alternate first and second word, first word first.
// - Read-back mode persists until the initialization command is issued again.
// - First word bits 9:8 pick normal, upper, midpoint or lower reference.
// - Test conversions are straight binary; format bit 7 is ignored then.
// - Test codes sit near 4095, 2047 and 0 respectively.
// - Data-ready output stays inactive in test mode; host polls the data.
// - Overwriting an unread FIFO entry sets a sticky overflow flag.
// - Initialization clears the overflow flag.
// - Conversions keep running in read-back mode, so overflow may still occur.
// - Test conversions use the currently selected internal or external reference.
// - Bits 5:4 of the second word choose the data-ready output form.
//////////////////////////////////////////////////////////////////////////////////////////
module adt_debug_ctrl #(
    parameter int unsigned DEPTH = adt_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        sample_valid_i,
    input  wire logic [11:0] sample_data_i,
    output logic      [1:0]  test_sel_o,
    output logic             ref_ext_o,
    output logic             data_ready_signal_o,
    output logic             irq_o
);

    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = PTR_W + 1;

    if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 16");
    end

    //////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] merge10(input logic [9:0]  old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
        logic [9:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[9:8] = wd[9:8];
        end
        return res;
    endfunction

    logic [9:0]              cw0_q;
    logic [9:0]              cw1_q;
    logic                    ovf_q;
    logic                    rb_sel_q;
    logic                    ack_q;
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;
    logic [11:0]             mem_q [DEPTH];
    logic [PTR_W-1:0]        wr_ptr_q;
    logic [PTR_W-1:0]        rd_ptr_q;
    logic [CNT_W-1:0]        count_q;
    logic [CNT_W-1:0]        blk_q;
    logic                    arm_q;
    logic [adt_pkg::IRQ_W-1:0] ist_q;
    logic [adt_pkg::IRQ_W-1:0] ien_q;

    logic                    acc;
    logic                    rd_done;
    logic                    wr_done;
    logic                    sel_cw0;
    logic                    sel_cw1;
    logic                    sel_data;
    logic                    sel_init;
    logic                    sel_iclr;
    logic                    sel_ien;
    logic                    init_w;
    logic                    rb_q;
    logic                    test_q;
    logic                    push;
    logic                    pop;
    logic                    full;
    logic                    overwrite;
    logic                    trig;
    logic                    first_read;
    logic [11:0]             wr_data;
    logic [CNT_W-1:0]        tl_eff;
    localparam int unsigned  TL_W_FIX = adt_pkg::TL_W;
    logic [TL_W_FIX-1:0]     tl_raw;
    logic [10:0]             cw1_rb;

    //////////////////////////////////////////////////////////////////////////////////////
    // Every access takes exactly one wait cycle: the answer is ready at the second edge.
    assign acc               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = acc & ~ack_q;
    assign rd_done           = avs_read_i & ack_q;
    assign wr_done           = avs_write_i & ack_q;

    always_comb begin
        sel_cw0  = 1'b0;
        sel_cw1  = 1'b0;
        sel_data = 1'b0;
        sel_init = 1'b0;
        sel_iclr = 1'b0;
        sel_ien  = 1'b0;
        if (avs_address_i == adt_pkg::ADDR_CW0) begin
            sel_cw0 = 1'b1;
        end else if (avs_address_i == adt_pkg::ADDR_CW1) begin
            sel_cw1 = 1'b1;
        end else if (avs_address_i == adt_pkg::ADDR_DATA) begin
            sel_data = 1'b1;
        end else if (avs_address_i == adt_pkg::ADDR_INIT) begin
            sel_init = 1'b1;
        end else if (avs_address_i == adt_pkg::ADDR_ICLR) begin
            sel_iclr = 1'b1;
        end else if (avs_address_i == adt_pkg::ADDR_IEN) begin
            sel_ien = 1'b1;
        end
    end

    assign init_w = wr_done & sel_init;
    assign rb_q   = cw1_q[adt_pkg::CW1_RB];
    assign test_q = cw0_q[adt_pkg::CW0_TSEL_LO +: 2] != adt_pkg::TSEL_NORMAL;
    // The flag is also readable in the status word; here it is folded above the second word.
    assign cw1_rb = {ovf_q, cw1_q};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc & ~ack_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (avs_address_i == adt_pkg::ADDR_CW0) begin
            rdata_d[9:0] = cw0_q;
        end else if (avs_address_i == adt_pkg::ADDR_CW1) begin
            rdata_d[10:0] = cw1_rb;
        end else if (avs_address_i == adt_pkg::ADDR_DATA) begin
            if (rb_q) begin
                rdata_d[10:0] = rb_sel_q ? cw1_rb : {1'b0, cw0_q};
            end else if (count_q != '0) begin
                rdata_d[11:0] = mem_q[rd_ptr_q];
            end
        end else if (avs_address_i == adt_pkg::ADDR_ISTAT) begin
            rdata_d[adt_pkg::IRQ_W-1:0] = ist_q;
        end else if (avs_address_i == adt_pkg::ADDR_IEN) begin
            rdata_d[adt_pkg::IRQ_W-1:0] = ien_q;
        end else if (avs_address_i == adt_pkg::ADDR_STAT) begin
            rdata_d[CNT_W+3:0] = {rb_sel_q, test_q, rb_q, ovf_q, count_q};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_o = rdata_q;

    //////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cw0_q <= adt_pkg::CW0_RST;
        end else if (init_w) begin
            cw0_q <= adt_pkg::CW0_RST;
        end else if (wr_done && sel_cw0) begin
            cw0_q <= merge10(cw0_q, avs_writedata_i, avs_byteenable_i);
        end
    end

    // Once set, the read-back bit can only be left through initialization.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cw1_q <= adt_pkg::CW1_RST;
        end else if (init_w) begin
            cw1_q <= adt_pkg::CW1_RST;
        end else if (wr_done && sel_cw1) begin
            cw1_q <= merge10(cw1_q, avs_writedata_i, avs_byteenable_i);
            if (rb_q) begin
                cw1_q[adt_pkg::CW1_RB] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rb_sel_q <= 1'b0;
        end else if (init_w || !rb_q) begin
            rb_sel_q <= 1'b0;
        end else if (rd_done && sel_data) begin
            rb_sel_q <= ~rb_sel_q;
        end
    end

    // The reference choice is not overridden by test mode.
    assign ref_ext_o  = cw0_q[adt_pkg::CW0_REF_EXT];
    assign test_sel_o = cw0_q[adt_pkg::CW0_TSEL_LO +: 2];

    //////////////////////////////////////////////////////////////////////////////////////
    // Samples keep arriving in every mode; the FIFO drops its oldest entry when full.
    assign push      = sample_valid_i & ~init_w;
    assign pop       = rd_done & sel_data & ~rb_q & (count_q != '0);
    assign full      = count_q == CNT_W'(DEPTH);
    assign overwrite = push & full & ~pop;

    // Two's complement is only offered for real input conversions.
    always_comb begin
        wr_data = sample_data_i;
        if (cw1_q[adt_pkg::CW1_FMT] && !test_q) begin
            wr_data[11] = ~sample_data_i[11];
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (init_w) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop || overwrite) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop && !full) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // No overflow can arise in the initialization cycle, since no sample is pushed then.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
        end else if (overwrite) begin
            ovf_q <= 1'b1;
        end else if (init_w) begin
            ovf_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Trigger level zero stands for the full depth.
    assign tl_raw = cw1_q[adt_pkg::CW1_TL_LO +: adt_pkg::TL_W];
    assign tl_eff = (tl_raw == '0) ? CNT_W'(DEPTH) : CNT_W'(tl_raw);
    assign trig   = arm_q & (count_q >= tl_eff);
    assign first_read = pop & (blk_q == '0);

    // The next trigger waits until a whole block of trigger-level words has been read.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_q <= 1'b1;
            blk_q <= '0;
        end else if (init_w) begin
            arm_q <= 1'b1;
            blk_q <= '0;
        end else begin
            if (trig) begin
                arm_q <= 1'b0;
            end
            if (pop && !arm_q) begin
                if (blk_q + 1'b1 >= tl_eff) begin
                    blk_q <= '0;
                    arm_q <= 1'b1;
                end else begin
                    blk_q <= blk_q + 1'b1;
                end
            end
        end
    end

    adt_drdy u_drdy (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .trig_i       (trig),
        .first_read_i (first_read),
        .dis_i        (rb_q | test_q),
        .cfg_i        (cw1_q[adt_pkg::CW1_DR_PLS +: 2]),
        .drdy_o       (data_ready_signal_o)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ist_q <= '0;
        end else begin
            ist_q[adt_pkg::IRQ_OVF]  <= overwrite |
                (ist_q[adt_pkg::IRQ_OVF] & ~(wr_done & sel_iclr &
                avs_byteenable_i[0] & avs_writedata_i[adt_pkg::IRQ_OVF]));
            ist_q[adt_pkg::IRQ_TRIG] <= trig |
                (ist_q[adt_pkg::IRQ_TRIG] & ~(wr_done & sel_iclr &
                avs_byteenable_i[0] & avs_writedata_i[adt_pkg::IRQ_TRIG]));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ien_q <= '0;
        end else if (wr_done && sel_ien && avs_byteenable_i[0]) begin
            ien_q <= avs_writedata_i[adt_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(ist_q & ien_q);

    //////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rb_read;
        rd_done && sel_data && rb_q;
    endsequence

    a_rb_first_word: assert property ($rose(rb_q) |-> !rb_sel_q)
        else $error("read-back did not start with the first word");
    a_rb_alternate: assert property (s_rb_read ##1 rb_q |-> rb_sel_q != $past(rb_sel_q))
        else $error("read-back words did not alternate");
    a_rb_enter: assert property (wr_done && sel_cw1 && avs_byteenable_i[1]
            && avs_writedata_i[9] |=> rb_q)
        else $error("read-back mode not entered");
    a_rb_sticky: assert property (rb_q && !init_w |=> rb_q)
        else $error("read-back mode left without initialization");
    a_rb_quiet: assert property (rb_q [*2] ##0 $stable(cw1_q)
            |-> data_ready_signal_o == !cw1_q[adt_pkg::CW1_DR_POL])
        else $error("data ready active in read-back mode");
    a_test_quiet: assert property (test_q && $past(test_q) && $stable(cw1_q)
            |-> data_ready_signal_o == !cw1_q[adt_pkg::CW1_DR_POL])
        else $error("data ready active in test mode");
    a_ovf_set: assert property (overwrite |=> ovf_q ##1 (ovf_q || $past(init_w)))
        else $error("overflow flag not set or not held");
    a_ovf_clear: assert property (init_w && !overwrite |=> !ovf_q)
        else $error("initialization left overflow flag set");
    a_rb_no_pop: assert property (s_rb_read and !push |=> $stable(rd_ptr_q)
            && count_q == $past(count_q))
        else $error("read-back read consumed a sample");
    a_test_binary: assert property (push && test_q |=> mem_q[$past(wr_ptr_q)]
            == $past(sample_data_i))
        else $error("test sample not stored in straight binary");
    a_tsel_follow: assert property (wr_done && sel_cw0 && avs_byteenable_i[1] && !init_w
            |=> test_sel_o == $past(avs_writedata_i[9:8]))
        else $error("test source select did not follow the first word");

endmodule

//--- logic/adt_pkg.sv
package adt_pkg;

    localparam int unsigned DATA_W      = 12;
    localparam int unsigned CW_W        = 10;
    localparam int unsigned FIFO_DEPTH  = 16;

    // Word offsets on the register bus (byte addresses).
    localparam logic [4:0]  ADDR_CW0    = 5'h00;
    localparam logic [4:0]  ADDR_CW1    = 5'h04;
    localparam logic [4:0]  ADDR_DATA   = 5'h08;
    localparam logic [4:0]  ADDR_INIT   = 5'h0C;
    localparam logic [4:0]  ADDR_ISTAT  = 5'h10;
    localparam logic [4:0]  ADDR_ICLR   = 5'h14;
    localparam logic [4:0]  ADDR_IEN    = 5'h18;
    localparam logic [4:0]  ADDR_STAT   = 5'h1C;

    // First control word fields.
    localparam int unsigned CW0_TSEL_LO = 8;
    localparam int unsigned CW0_REF_EXT = 3;
    // Second control word fields.
    localparam int unsigned CW1_RB      = 9;
    localparam int unsigned CW1_FMT     = 7;
    localparam int unsigned CW1_DR_POL  = 5;
    localparam int unsigned CW1_DR_PLS  = 4;
    localparam int unsigned CW1_TL_LO   = 0;
    localparam int unsigned TL_W        = 4;
    // Overflow flag position in the second word as read back.
    localparam int unsigned RB_OVF_BIT  = 10;

    localparam logic [CW_W-1:0] CW0_RST = 10'h000;
    localparam logic [CW_W-1:0] CW1_RST = 10'h030;

    localparam logic [1:0]  TSEL_NORMAL = 2'h0;
    localparam logic [1:0]  TSEL_UPPER  = 2'h1;
    localparam logic [1:0]  TSEL_MID    = 2'h2;
    localparam logic [1:0]  TSEL_LOWER  = 2'h3;

    // Nominal codes of the test sources, for checking with a tolerance.
    localparam logic [DATA_W-1:0] CODE_UPPER = 12'hFFF;
    localparam logic [DATA_W-1:0] CODE_MID   = 12'h7FF;
    localparam logic [DATA_W-1:0] CODE_LOWER = 12'h000;

    localparam int unsigned IRQ_OVF     = 0;
    localparam int unsigned IRQ_TRIG    = 1;
    localparam int unsigned IRQ_W       = 2;

endpackage

//--- logic/adt_drdy.sv
module adt_drdy (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       trig_i,
    input  wire logic       first_read_i,
    input  wire logic       dis_i,
    input  wire logic [1:0] cfg_i,
    output logic            drdy_o
);

    logic act_q;
    logic act_d;
    logic out_q;

    // Level form holds until the first read of the block; pulse form lasts one cycle.
    always_comb begin
        act_d = act_q;
        if (dis_i) begin
            act_d = 1'b0;
        end else if (trig_i) begin
            act_d = 1'b1;
        end else if (cfg_i[0] || first_read_i) begin
            act_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_q <= 1'b0;
        end else begin
            act_q <= act_d;
        end
    end

    // Polarity is applied before the output register, so a polarity change keeps the old level for one cycle under the new polarity.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
        end else begin
            out_q <= cfg_i[1] ? act_d : ~act_d;
        end
    end

    assign drdy_o = out_q;

endmodule

//--- tb/adt_conv_model.sv
////////////////////////////////////////////////////////////////////////////////
// Converter core stand-in: one result every PER cycles while run_i is high.
module adt_conv_model #(
    parameter int PER = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic [1:0]  test_sel_i,
    input  wire logic        ref_ext_i,
    input  wire logic [11:0] analog_i,
    output logic             sample_valid_o,
    output logic [11:0]      sample_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  cnt_q;
    logic [11:0] code;

    ////////////////////////////////////////////////////////////////////////////
    // The reference choice shifts the upper and lower test codes by one step, so a wrong
    // reference select shows up without leaving the tolerance band.
    always_comb begin
        case (test_sel_i)
            2'h1:    code = 12'hFFE - 12'(ref_ext_i);
            2'h2:    code = 12'h7FE;
            2'h3:    code = 12'h002 + 12'(ref_ext_i);
            default: code = analog_i;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data toggles outside valid cycles so that stale values are never reused.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q          <= 8'h00;
            sample_valid_o <= 1'b0;
            sample_data_o  <= 12'h000;
        end else begin
            sample_valid_o <= 1'b0;
            sample_data_o  <= ~sample_data_o;
            if (run_i) begin
                if (cnt_q == 8'(PER - 1)) begin
                    cnt_q          <= 8'h00;
                    sample_valid_o <= 1'b1;
                    sample_data_o  <= code;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule

//--- tb/tb_top.sv
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i         = 1'b0;
    logic        rst_i         = 1'b1;
    logic [4:0]  avs_address   = 5'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sample_valid;
    logic [11:0] sample_data;
    logic [1:0]  test_sel;
    logic        ref_ext;
    logic        data_ready;
    logic        irq;
    logic        run           = 1'b0;
    logic [11:0] analog        = 12'h123;
    int          error_cnt     = 0;
    int          checks_done   = 0;
    int          cyc           = 0;

    always #5 clk_i = ~clk_i;

    adt_debug_ctrl #(.DEPTH(16)) i_adt_debug_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .sample_valid_i(sample_valid),
        .sample_data_i(sample_data), .test_sel_o(test_sel), .ref_ext_o(ref_ext),
        .data_ready_signal_o(data_ready), .irq_o(irq));

    adt_conv_model #(.PER(8)) i_adt_conv_model (
        .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .test_sel_i(test_sel),
        .ref_ext_i(ref_ext), .analog_i(analog), .sample_valid_o(sample_valid),
        .sample_data_o(sample_data));

    ////////////////////////////////////////////////////////////////////////////
    // Waitrequest and read data are taken at the rising edge, before the design's updates land.
    // Only the bench timeout ends a wait; the idle edge at the end keeps two calls apart.
    task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic w;
        int   n;
        n = 0;
        w = 1'b1;
        q = 32'h0000_0000;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr_en;
        avs_read      <= ~wr_en;
        while (w !== 1'b0) begin
            @(posedge clk_i);
            w = avs_waitrequest;
            q = avs_readdata;
            n++;
        end
        `CHK(n, 2)
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0000_0000, q);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] q;
        @(negedge clk_i);
        `CHK(test_sel, 2'h0)
        `CHK(ref_ext, 1'b0)
        `CHK(data_ready, 1'b0)
        `CHK(irq, 1'b0)
        @(posedge clk_i);
        rd(adt_pkg::ADDR_CW1, q);
        `CHK(q, 32'h0000_0030)
    endtask

    task automatic t_forms;
        logic [31:0] q;
        logic        act;
        int          n;
        for (int f = 0; f < 4; f++) begin
            act = f[1];
            wr(adt_pkg::ADDR_INIT, 32'h0000_0001);
            wr(adt_pkg::ADDR_CW1, 32'h0000_0081 | 32'(f << 4));
            run <= 1'b1;
            @(negedge clk_i);
            `CHK(data_ready, ~act)
            n = 0;
            while (data_ready !== act && n < 40) begin
                @(negedge clk_i);
                n++;
            end
            @(posedge clk_i);
            run <= 1'b0;
            `CHK(n < 40, 1'b1)
            @(negedge clk_i);
            `CHK(data_ready, f[0] ? ~act : act)
            @(posedge clk_i);
            rd(adt_pkg::ADDR_DATA, q);
            `CHK(q[11:0], analog ^ 12'h800)
            @(negedge clk_i);
            `CHK(data_ready, ~act)
            @(posedge clk_i);
        end
    endtask

    task automatic t_test;
        logic [31:0] q;
        logic [11:0] nom;
        int          d;
        for (int s = 1; s < 4; s++) begin
            nom = (s == 1) ? adt_pkg::CODE_UPPER : (s == 2) ? adt_pkg::CODE_MID :
                  adt_pkg::CODE_LOWER;
            wr(adt_pkg::ADDR_INIT, 32'h0000_0001);
            wr(adt_pkg::ADDR_CW0, 32'((s << 8) | ((s & 1) << 3)));
            wr(adt_pkg::ADDR_CW1, 32'h0000_00A1);
            run <= 1'b1;
            repeat (40) begin
                @(negedge clk_i);
                `CHK(data_ready, 1'b0)
            end
            `CHK(test_sel, 2'(s))
            `CHK(ref_ext, 1'(s & 1))
            @(posedge clk_i);
            run <= 1'b0;
            rd(adt_pkg::ADDR_DATA, q);
            d = int'(q[11:0]) - int'(nom);
            `CHK((d >= -4 && d <= 4), 1'b1)
        end
    endtask

    task automatic t_readback;
        logic [31:0] q;
        wr(adt_pkg::ADDR_INIT, 32'h0000_0001);
        wr(adt_pkg::ADDR_CW0, 32'h0000_0008);
        wr(adt_pkg::ADDR_IEN, 32'h0000_0001);
        run <= 1'b1;
        repeat (200) @(negedge clk_i);
        `CHK(irq, 1'b1)
        @(posedge clk_i);
        wr(adt_pkg::ADDR_CW1, 32'h0000_02A1);
        repeat (3) begin
            @(negedge clk_i);
            `CHK(data_ready, 1'b0)
        end
        @(posedge clk_i);
        wr(adt_pkg::ADDR_ICLR, 32'h0000_0001);
        repeat (20) @(negedge clk_i);
        `CHK(irq, 1'b1)
        @(posedge clk_i);
        run <= 1'b0;
        repeat (4) @(posedge clk_i);
        wr(adt_pkg::ADDR_IEN, 32'h0000_0000);
        `CHK(irq, 1'b0)
        wr(adt_pkg::ADDR_IEN, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wr(adt_pkg::ADDR_ICLR, 32'h0000_0001);
        `CHK(irq, 1'b0)
        for (int i = 0; i < 4; i++) begin
            rd(adt_pkg::ADDR_DATA, q);
            `CHK(q, i[0] ? 32'h0000_06A1 : 32'h0000_0008)
        end
        rd(adt_pkg::ADDR_STAT, q);
        `CHK(q[8:0], 9'h070)
        wr(adt_pkg::ADDR_CW1, 32'h0000_00A1);
        rd(adt_pkg::ADDR_DATA, q);
        `CHK(q, 32'h0000_0008)
        wr(adt_pkg::ADDR_INIT, 32'h0000_0001);
        rd(adt_pkg::ADDR_CW1, q);
        `CHK(q, 32'h0000_0030)
        rd(adt_pkg::ADDR_STAT, q);
        `CHK(q[7:0], 8'h00)
        rd(adt_pkg::ADDR_DATA, q);
        `CHK(q, 32'h0000_0000)
        rd(adt_pkg::ADDR_INIT, q);
        `CHK(q, 32'h0000_0000)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The whole run takes under 2000 cycles, so 5000 means a hang.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict;
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_forms;
        t_test;
        t_readback;
        give_verdict;
    end
endmodule
